//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, txn_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
  logic [1:0] htrans = 2'h0, slot_class = 2'h0;
  logic [2:0] hsize = 3'h2, slot_valid = 3'h0;
  logic [3:0] txn_supplier = 4'h0, txn_probe = 4'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, txn_match, monitor_overflow_interrupt;
  int fail_count = 0;
  int tests_run = 0;

  topdown_monitor u_topdown_monitor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txn_valid(txn_valid),
    .txn_supplier(txn_supplier), .txn_probe(txn_probe), .slot_valid(slot_valid),
    .slot_class(slot_class), .txn_match(txn_match),
    .monitor_overflow_interrupt(monitor_overflow_interrupt)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait; a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fail_count++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    v = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, v, exp);
  endtask

  task automatic mchk(input logic [31:0] lo, hi, input logic [3:0] s, p, input logic e);
    xfer(1'b1, topdown_pkg::ofs_filter_lo, lo);
    xfer(1'b1, topdown_pkg::ofs_filter_hi, hi);
    txn_valid <= 1'b1;
    txn_supplier <= s;
    txn_probe <= p;
    @(posedge hclk);
    txn_valid <= 1'b0;
    @(posedge hclk);
    chk("txn_match", {31'h0, txn_match}, {31'h0, e});
  endtask

  // three slots a cycle, then idle so the fractions settle
  task automatic slots(input logic [1:0] c, input int n);
    slot_class <= c;
    slot_valid <= 3'h3;
    repeat (n) @(posedge hclk);
    slot_valid <= 3'h0;
    repeat (2) @(posedge hclk);
  endtask

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("metrics_hi", topdown_pkg::ofs_metrics_hi, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    xfer(1'b0, topdown_pkg::ofs_capabilities, 32'h0);
    chk("capabilities", v & 32'h0000_8000, 32'h0000_8000);
    $display("test registers done");
    mchk(32'h0001_0000, 32'h0, 4'h3, 4'h3, 1'b1);
    mchk(32'h0005_0000, 32'h0000_00c0, 4'h2, 4'h1, 1'b1);
    mchk(32'h8400_0000, 32'h1, 4'h0, 4'h0, 1'b1);
    mchk(32'h8400_0000, 32'h0, 4'h0, 4'h0, 1'b0);
    mchk(32'h0400_0000, 32'h20, 4'h1, 4'h2, 1'b1);
    mchk(32'h0400_0000, 32'h20, 4'h0, 4'h2, 1'b0);
    mchk(32'hffc0_0000, 32'h3f, 4'h3, 4'h1, 1'b1);
    mchk(32'hffc0_0000, 32'h3f, 4'h2, 4'h1, 1'b0);
    mchk(32'h001c_0000, 32'h1, 4'h2, 4'h0, 1'b1);
    mchk(32'h000c_0000, 32'h1, 4'h2, 4'h0, 1'b0);
    mchk(32'h001c_0000, 32'h2, 4'h2, 4'h1, 1'b1);
    mchk(32'h001c_0000, 32'h4, 4'h2, 4'h2, 1'b1);
    mchk(32'h001c_0000, 32'h10, 4'h2, 4'h3, 1'b1);
    mchk(32'h001c_0000, 32'h10, 4'h2, 4'h2, 1'b0);
    $display("test filter done");
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0001_0008);
    slots(2'h0, 8);
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0);
    rchk("metrics_lo", topdown_pkg::ofs_metrics_lo, 32'h0000_00ff);
    rchk("slot_lo", topdown_pkg::ofs_slot_lo, 32'h18);
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0001_0000);
    slots(2'h3, 8);
    rchk("metrics_lo", topdown_pkg::ofs_metrics_lo, 32'h0000_00ff);
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0);
    xfer(1'b1, topdown_pkg::ofs_slot_lo, 32'h0);
    xfer(1'b1, topdown_pkg::ofs_metrics_lo, 32'h0);
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0001_0008);
    slots(2'h1, 4);
    slots(2'h2, 4);
    xfer(1'b1, topdown_pkg::ofs_global_ctrl_hi, 32'h0);
    rchk("metrics_lo", topdown_pkg::ofs_metrics_lo, 32'h007f_7f00);
    $display("test metrics done");
    xfer(1'b1, topdown_pkg::ofs_status_hi, 32'h0001_0000);
    rchk("status", topdown_pkg::ofs_status_hi, 32'h0);
    xfer(1'b1, topdown_pkg::ofs_status_set_hi, 32'h0001_0000);
    rchk("status", topdown_pkg::ofs_status_hi, 32'h0001_0000);
    chk("interrupt", {31'h0, monitor_overflow_interrupt}, 32'h1);
    xfer(1'b1, topdown_pkg::ofs_status_clr_hi, 32'h0001_0000);
    rchk("status", topdown_pkg::ofs_status_hi, 32'h0);
    chk("interrupt", {31'h0, monitor_overflow_interrupt}, 32'h0);
    $display("test status done");
    give_verdict();
  end
endmodule

//--- dv/topdown_chk.sv
module topdown_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic txn_valid,
  input wire logic [3:0] txn_supplier,
  input wire logic [3:0] txn_probe,
  input wire logic txn_match,
  input wire logic monitor_overflow_interrupt
);
  logic pw_r;
  logic [7:0] pa_r;
  logic [63:0] flt_r;
  wire wr = pw_r && hready;
  wire [5:0] pb = (txn_probe == 4'h3) ? 6'h24 : 6'h20 + {4'h0, txn_probe[1:0]};
  wire hit = txn_supplier == topdown_pkg::sup_llc_hit && txn_probe < 4'h4 && flt_r[pb]
    && (flt_r & topdown_pkg::mask_llc_hit) == topdown_pkg::mask_llc_hit;
  wire dram = txn_supplier == topdown_pkg::sup_dram
    && (flt_r & topdown_pkg::mask_dram) == topdown_pkg::mask_dram;
  wire ndram = txn_supplier == topdown_pkg::sup_non_dram
    && (flt_r & topdown_pkg::mask_non_dram) == topdown_pkg::mask_non_dram;
  wire miss = txn_supplier != topdown_pkg::sup_llc_hit
    && (flt_r & topdown_pkg::mask_llc_miss) == topdown_pkg::mask_llc_miss;
  // filter shadow, filled from the bus write data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pw_r <= 1'b0;
      pa_r <= 8'h00;
      flt_r <= 64'h0;
    end
    else
    begin
      if (hready)
        pw_r <= hsel && htrans[1] && hwrite;
      if (hready)
        pa_r <= haddr[7:0];
      if (wr && pa_r == topdown_pkg::ofs_filter_lo)
        flt_r[31:0] <= hwdata;
      if (wr && pa_r == topdown_pkg::ofs_filter_hi)
        flt_r[63:32] <= hwdata;
    end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_any;
    txn_valid && flt_r[16] |=> txn_match;
  endproperty
  a_any: assert property (p_any)
    else $error("catch-all filter missed a response");
  property p_dram;
    txn_valid && dram |=> txn_match;
  endproperty
  a_dram: assert property (p_dram)
    else $error("dram subtype missed");
  property p_ndram;
    txn_valid && ndram |=> txn_match;
  endproperty
  a_ndram: assert property (p_ndram)
    else $error("non-dram subtype missed");
  property p_miss;
    txn_valid && miss |=> txn_match;
  endproperty
  a_miss: assert property (p_miss)
    else $error("llc miss subtype missed");
  property p_hit;
    txn_valid && hit |=> txn_match;
  endproperty
  a_hit: assert property (p_hit)
    else $error("llc hit with probe bit missed");
  property p_none;
    txn_valid && !flt_r[16] && !dram && !ndram && !miss && !hit |=> !txn_match;
  endproperty
  a_none: assert property (p_none)
    else $error("partial selection matched");
  property p_set;
    wr && pa_r == topdown_pkg::ofs_status_set_hi && hwdata[16] |-> ##2 monitor_overflow_interrupt;
  endproperty
  a_set: assert property (p_set)
    else $error("status set gave no interrupt");
  property p_clr;
    wr && pa_r == topdown_pkg::ofs_status_clr_hi && hwdata[16] |-> ##2 !monitor_overflow_interrupt;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status clear left interrupt up");
  c_match: cover property (txn_valid ##1 txn_match);
  c_hit: cover property (txn_valid && hit);
  c_irq: cover property ($rose(monitor_overflow_interrupt));
endmodule

bind topdown_monitor topdown_chk u_topdown_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .txn_valid(txn_valid),
  .txn_supplier(txn_supplier), .txn_probe(txn_probe), .txn_match(txn_match),
  .monitor_overflow_interrupt(monitor_overflow_interrupt)
);

//--- logic/topdown_monitor.sv
module topdown_monitor #(
  parameter int slot_w = 48
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic txn_valid,
  input wire logic [3:0] txn_supplier,
  input wire logic [3:0] txn_probe,
  input wire logic [2:0] slot_valid,
  input wire logic [1:0] slot_class,
  output logic txn_match,
  output logic monitor_overflow_interrupt
);
  logic [63:0] offcore_response_filter_r;
  logic [31:0] metrics_lo_r;
  logic [31:0] ctrl_hi_r;
  logic metrics_overflow_flag_r;
  logic slot_ovf_r;
  logic [slot_w-1:0] slot_cnt_r;
  logic [slot_w-1:0] cls_cnt_r [4];
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic match_r;
  logic irq_r;

  // bus decode
  wire logic addr_ok = hsel & hready & htrans[1];
  wire logic wr_go = wr_pend_r;
  wire logic [31:0] wd = hwdata;
  wire logic wr_filter_lo = wr_go & (wr_addr_r == topdown_pkg::ofs_filter_lo);
  wire logic wr_filter_hi = wr_go & (wr_addr_r == topdown_pkg::ofs_filter_hi);
  wire logic wr_metrics = wr_go & (wr_addr_r == topdown_pkg::ofs_metrics_lo);
  wire logic wr_ctrl = wr_go & (wr_addr_r == topdown_pkg::ofs_global_ctrl_hi);
  wire logic wr_set = wr_go & (wr_addr_r == topdown_pkg::ofs_status_set_hi);
  wire logic wr_clr = wr_go & (wr_addr_r == topdown_pkg::ofs_status_clr_hi);
  wire logic wr_slot_lo = wr_go & (wr_addr_r == topdown_pkg::ofs_slot_lo);
  wire logic wr_slot_hi = wr_go & (wr_addr_r == topdown_pkg::ofs_slot_hi);

  // filter matching
  wire logic [63:0] f = offcore_response_filter_r;
  function automatic logic all_set(input logic [63:0] v, input logic [63:0] m);
    all_set = ((v & m) == m);
  endfunction
  wire logic sel_dram = all_set(f, topdown_pkg::mask_dram);
  wire logic sel_non_dram = all_set(f, topdown_pkg::mask_non_dram);
  wire logic sel_llc_miss = all_set(f, topdown_pkg::mask_llc_miss);
  wire logic sel_llc_hit = all_set(f, topdown_pkg::mask_llc_hit);
  wire logic m_dram = sel_dram & (txn_supplier == topdown_pkg::sup_dram);
  wire logic m_non_dram = sel_non_dram & (txn_supplier == topdown_pkg::sup_non_dram);
  wire logic m_llc_miss = sel_llc_miss & (txn_supplier != topdown_pkg::sup_llc_hit);
  wire logic m_sup = sel_llc_hit & (txn_supplier == topdown_pkg::sup_llc_hit);
  wire logic p_none = f[topdown_pkg::bit_probe_none] & (txn_probe == topdown_pkg::probe_none);
  wire logic p_miss = f[topdown_pkg::bit_probe_miss] & (txn_probe == topdown_pkg::probe_miss);
  wire logic p_clean = f[topdown_pkg::bit_probe_clean] & (txn_probe == topdown_pkg::probe_clean);
  wire logic p_mod = f[topdown_pkg::bit_probe_mod] & (txn_probe == topdown_pkg::probe_mod);
  wire logic m_probe = p_none | p_miss | p_clean | p_mod;
  wire logic m_any = f[topdown_pkg::bit_any];
  // other bits ignored under any; an unprogrammed filter never matches
  wire logic m_all = m_any | m_dram | m_non_dram | m_llc_miss | (m_sup & m_probe);
  wire logic match_nxt = txn_valid & m_all;

  wire logic slot_en = ctrl_hi_r[topdown_pkg::hi_slot_en];
  wire logic metrics_on = ctrl_hi_r[topdown_pkg::hi_metrics] & slot_en;
  wire logic [slot_w-1:0] slot_inc = {{(slot_w-3){1'b0}}, slot_valid};
  wire logic [slot_w:0] slot_sum = {1'b0, slot_cnt_r} + {1'b0, slot_inc};
  wire logic slot_wrap = slot_en & slot_sum[slot_w];
  logic [3:0] cls_wrap;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_cls
      wire logic hit = metrics_on & (slot_class == 2'(g));
      wire logic [slot_w:0] s = {1'b0, cls_cnt_r[g]} + {1'b0, slot_inc};
      assign cls_wrap[g] = hit & s[slot_w];
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cls_cnt_r[g] <= '0;
        else if (wr_metrics | (wr_slot_lo & wd == 32'h0000_0000))
          cls_cnt_r[g] <= '0;
        else if (hit)
          cls_cnt_r[g] <= s[slot_w-1:0];
      end
    end
  endgenerate

  // fraction of 255 per class, from live counts
  function automatic logic [7:0] frac(input logic [slot_w-1:0] c, input logic [slot_w-1:0] t);
    logic [slot_w+7:0] num;
    num = {c, 8'h00} - {8'h00, c};
    frac = (t == '0) ? 8'h00 : 8'((num / {8'h00, t}));
  endfunction
  wire logic [slot_w-1:0] tot = cls_cnt_r[0] + cls_cnt_r[1] + cls_cnt_r[2] + cls_cnt_r[3];
  wire logic [31:0] metrics_live = {frac(cls_cnt_r[3], tot), frac(cls_cnt_r[2], tot),
                                    frac(cls_cnt_r[1], tot), frac(cls_cnt_r[0], tot)};
  wire logic metrics_ovf_evt = |cls_wrap;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      offcore_response_filter_r <= 64'h0000_0000_0000_0000;
    else if (wr_filter_lo)
      offcore_response_filter_r[31:0] <= wd;
    else if (wr_filter_hi)
      offcore_response_filter_r[63:32] <= wd;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_hi_r <= 32'h0000_0000;
    else if (wr_ctrl)
      ctrl_hi_r <= wd;
  end

  // written value is held until counting resumes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      metrics_lo_r <= 32'h0000_0000;
    else if (wr_metrics)
      metrics_lo_r <= wd;
    else if (metrics_on)
      metrics_lo_r <= metrics_live;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slot_cnt_r <= '0;
    else if (wr_slot_lo)
      slot_cnt_r[31:0] <= wd;
    else if (wr_slot_hi)
      slot_cnt_r[slot_w-1:32] <= wd[slot_w-33:0];
    else if (slot_en)
      slot_cnt_r <= slot_sum[slot_w-1:0];
  end

  // set wins over clear: hardware events and set-writes beat clear-writes
  wire logic set_ovf = (wr_set & wd[topdown_pkg::hi_metrics]) | metrics_ovf_evt;
  wire logic set_slot = (wr_set & wd[topdown_pkg::hi_slot_en]) | slot_wrap;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      metrics_overflow_flag_r <= 1'b0;
      slot_ovf_r <= 1'b0;
    end
    else
    begin
      if (set_ovf)
        metrics_overflow_flag_r <= 1'b1;
      else if (wr_clr & wd[topdown_pkg::hi_metrics])
        metrics_overflow_flag_r <= 1'b0;
      if (set_slot)
        slot_ovf_r <= 1'b1;
      else if (wr_clr & wd[topdown_pkg::hi_slot_en])
        slot_ovf_r <= 1'b0;
    end
  end

  // read mux
  wire logic [31:0] status_hi = 32'(metrics_overflow_flag_r) << topdown_pkg::hi_metrics
                              | 32'(slot_ovf_r) << topdown_pkg::hi_slot_en;
  logic [31:0] rd_mux;
  always_comb
  begin
    case (haddr[7:0])
      topdown_pkg::ofs_filter_lo: rd_mux = offcore_response_filter_r[31:0];
      topdown_pkg::ofs_filter_hi: rd_mux = offcore_response_filter_r[63:32];
      topdown_pkg::ofs_metrics_lo: rd_mux = metrics_lo_r;
      topdown_pkg::ofs_global_ctrl_hi: rd_mux = ctrl_hi_r;
      topdown_pkg::ofs_status_hi: rd_mux = status_hi;
      topdown_pkg::ofs_capabilities: rd_mux = 32'(1) << topdown_pkg::cap_metrics_bit;
      topdown_pkg::ofs_slot_lo: rd_mux = slot_cnt_r[31:0];
      topdown_pkg::ofs_slot_hi: rd_mux = 32'(slot_cnt_r[slot_w-1:32]);
      topdown_pkg::ofs_match: rd_mux = 32'(match_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_r <= 32'h0000_0000;
      match_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (addr_ok & ~hwrite)
        rdata_r <= rd_mux;
      match_r <= match_nxt;
      irq_r <= metrics_overflow_flag_r | slot_ovf_r;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign txn_match = match_r;
  assign monitor_overflow_interrupt = irq_r;
endmodule

//--- logic/topdown_pkg.sv
package topdown_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ofs_filter_lo = 8'h00;
  localparam logic [7:0] ofs_filter_hi = 8'h04;
  localparam logic [7:0] ofs_metrics_lo = 8'h08;
  localparam logic [7:0] ofs_metrics_hi = 8'h0c;
  localparam logic [7:0] ofs_global_ctrl_hi = 8'h10;
  localparam logic [7:0] ofs_status_hi = 8'h14;
  localparam logic [7:0] ofs_status_set_hi = 8'h18;
  localparam logic [7:0] ofs_status_clr_hi = 8'h1c;
  localparam logic [7:0] ofs_capabilities = 8'h20;
  localparam logic [7:0] ofs_slot_lo = 8'h24;
  localparam logic [7:0] ofs_slot_hi = 8'h28;
  localparam logic [7:0] ofs_match = 8'h2c;
  // filter field positions (64-bit numbering)
  localparam int bit_any = 16;
  localparam int rsv_lo = 17;
  localparam int rsv_hi = 39;
  localparam logic [63:0] mask_dram = 64'h0000_0001_8400_0000;
  localparam logic [63:0] mask_non_dram = 64'h0000_0020_0400_0000;
  localparam logic [63:0] mask_llc_miss = 64'h0000_003f_ffc0_0000;
  localparam logic [63:0] mask_llc_hit = 64'h0000_0000_001c_0000;
  localparam int bit_probe_none = 32;
  localparam int bit_probe_miss = 33;
  localparam int bit_probe_clean = 34;
  localparam int bit_probe_mod = 36;
  // global control / status bits, as seen in the upper word (bit-32)
  localparam int hi_slot_en = 3;
  localparam int hi_metrics = 16;
  localparam int cap_metrics_bit = 15;
  localparam int field_w = 8;
  localparam logic [7:0] frac_full = 8'hff;
  // transaction response attributes
  localparam int resp_w = 4;
  localparam logic [3:0] sup_dram = 4'h0;
  localparam logic [3:0] sup_non_dram = 4'h1;
  localparam logic [3:0] sup_llc_hit = 4'h2;
  localparam logic [3:0] sup_other = 4'h3;
  localparam logic [3:0] probe_none = 4'h0;
  localparam logic [3:0] probe_miss = 4'h1;
  localparam logic [3:0] probe_clean = 4'h2;
  localparam logic [3:0] probe_mod = 4'h3;
endpackage
